// ---- src/pio_pkg.sv ----
/*
 * Shared constants of the port block: register indices, field
 * positions, reset values and port widths.
 * Assumes a 32-bit classic Wishbone bus; byte address = 4 * index.
 */
package pio_pkg;
    // Byte address width in bits on the bus.
    localparam int ADR_W = 18;
    // Port data register indices.
    localparam logic [15:0] IDX_P0 = 16'hff00;
    localparam logic [15:0] IDX_P2 = 16'hff02;
    localparam logic [15:0] IDX_P3 = 16'hff03;
    localparam logic [15:0] IDX_P4 = 16'hff04;
    localparam logic [15:0] IDX_P5 = 16'hff05;
    localparam logic [15:0] IDX_P7 = 16'hff07;
    localparam logic [15:0] IDX_P8 = 16'hff08;
    localparam logic [15:0] IDX_P9 = 16'hff09;
    // Direction register indices.
    localparam logic [15:0] IDX_DIR0 = 16'hff20;
    localparam logic [15:0] IDX_DIR3 = 16'hff23;
    localparam logic [15:0] IDX_DIR5 = 16'hff25;
    localparam logic [15:0] IDX_DIR8 = 16'hff28;
    localparam logic [15:0] IDX_DIR9 = 16'hff29;
    // Function select register indices.
    localparam logic [15:0] IDX_FSEL0 = 16'hff40;
    localparam logic [15:0] IDX_FSEL3 = 16'hff43;
    localparam logic [15:0] IDX_FSEL8 = 16'hff48;
    // Mode registers and the pin readback control register.
    localparam logic [15:0] IDX_MEMX = 16'hff50;
    localparam logic [15:0] IDX_TUM = 16'hff51;
    localparam logic [15:0] IDX_CLOCKED_SERIAL_MODE_REG = 16'hff52;
    localparam logic [15:0] IDX_PIN_READBACK_CONTROL = 16'hff62;
    // Field positions.
    localparam int MEMX_P4DIR_BIT = 0;
    localparam int TUM_CMD_BIT = 7;
    localparam int CLOCKED_SERIAL_MODE_REG_MOD_A_BIT = 3;
    localparam int CLOCKED_SERIAL_MODE_REG_MOD_B_BIT = 4;
    localparam int PIN_READBACK_CONTROL_PA_BIT = 0;
    // Reset values.
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] FSEL_RST = 8'h00;
    localparam logic MEMX_P4DIR_RST = 1'b1;
    localparam logic MODE_BIT_RST = 1'b0;
    localparam logic PIN_READBACK_CONTROL_PA_RST = 1'b0;
    // Port widths.
    localparam int W_P0 = 8;
    localparam int W_P2 = 6;
    localparam int W_P3 = 5;
    localparam int W_P4 = 8;
    localparam int W_P5 = 8;
    localparam int W_P7 = 8;
    localparam int W_P8 = 6;
    localparam int W_P9 = 3;
    localparam int W_ALL = W_P0 + W_P2 + W_P3 + W_P4 + W_P5 + W_P7 + W_P8
        + W_P9;
endpackage

// ---- src/pio_sync_if.sv ----
/*
 * Carrier between the port block and its pin synchroniser.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface pio_sync_if #(parameter int W = 8);
    logic [W-1:0] raw;
    logic [W-1:0] stable;
    modport user (output raw, input stable);
    modport sync (input raw, output stable);
endinterface
`default_nettype wire

// ---- src/pio_pin_sync.sv ----
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes raw pin levels are asynchronous to clk_i.
 */
`timescale 1ns/100ps
`default_nettype none
module pio_pin_sync #(
    parameter int W = 8
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Raw levels in, filtered levels out.
    pio_sync_if.sync sif
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] stable;

    // Shift chain; stage1 feeds only stage2 to keep metastability contained.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= sif.raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A bit changes only once stages two and three agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stable <= '0;
        end else begin
            stable <= (stage2 & stage3) | (stable & (stage2 ^ stage3));
        end
    end

    assign sif.stable = stable;
endmodule
`default_nettype wire

// ---- src/pio_port_io.sv ----
/*
 * Port logic: output latches, direction, function select, read mux,
 * pin readback mode, Wishbone register slave.
 * Assumes peripherals drive their control signals on clk_i.
 */
// Summary of operation
// - Reset sets every direction bit to input, releasing all pins.
// - Output latches are not reset; contents after reset are undefined.
// - Direction bit one means input, zero means output driving latch.
// - Reading an output bit returns the latch, not the pin.
// - Latch bits can be set or cleared singly and hold value.
// - Reading an input bit returns the sampled pin level.
// - Writes always reach the latch; it drives once bit turns output.
// - Two dedicated input ports have no drivers and no direction.
// - Port 4 direction comes from the memory expansion mode field.
// - Ports are eight, six, five, eight, eight, eight, six and three bits wide.
// - A set function select bit hands the pin to its peripheral.
// - Peripheral output pin reads pin if direction one, else signal.
// - Peripheral input pin reads pin if direction one, else zero; port 0 bits 5, 6 in counter mode read their output signal instead.
// - Port 0 bit 7 outputs and reads zero, or is clear input.
// - Counter mode turns port 0 bits 5 to 7 into counter inputs.
// - Serial mode bits choose roles of the two serial bus pins.
// - Port 0, 3 and 8 pins carry their listed peripheral signals.
// - Readback bit set makes output bits read the actual pin.
// - Reset clears the readback control register.
// - In readback mode input bits read as zero.
// - Readback register bits 7 to 1 ignore writes, read zero.
`timescale 1ns/100ps
`default_nettype none
module pio_port_io
    import pio_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Port pins.
    input wire logic [W_P0-1:0] p0_i,
    output logic [W_P0-1:0] p0_o,
    output logic [W_P0-1:0] p0_oe_o,
    input wire logic [W_P2-1:0] p2_i,
    input wire logic [W_P3-1:0] p3_i,
    output logic [W_P3-1:0] p3_o,
    output logic [W_P3-1:0] p3_oe_o,
    input wire logic [W_P4-1:0] p4_i,
    output logic [W_P4-1:0] p4_o,
    output logic [W_P4-1:0] p4_oe_o,
    input wire logic [W_P5-1:0] p5_i,
    output logic [W_P5-1:0] p5_o,
    output logic [W_P5-1:0] p5_oe_o,
    input wire logic [W_P7-1:0] p7_i,
    input wire logic [W_P8-1:0] p8_i,
    output logic [W_P8-1:0] p8_o,
    output logic [W_P8-1:0] p8_oe_o,
    input wire logic [W_P9-1:0] p9_i,
    output logic [W_P9-1:0] p9_o,
    output logic [W_P9-1:0] p9_oe_o,
    // Peripheral outputs toward the pins.
    input wire logic [3:0] realtime_outputs_i,
    input wire logic pwm_out_ch0_i,
    input wire logic pwm_out_ch1_i,
    input wire logic timer4_output_i,
    input wire logic [5:0] timer0_outputs_i,
    input wire logic txd_i,
    input wire logic so_i,
    input wire logic sbus_a_out_i,
    input wire logic sbus_a_oe_i,
    input wire logic sbus_b_out_i,
    input wire logic sbus_b_oe_i,
    input wire logic sck_out_i,
    input wire logic sck_oe_i,
    // Synchronised pin levels toward the peripherals.
    output logic updown_count_input_o,
    output logic updown_timer_input_o,
    output logic updown_clear_input_o,
    output logic rxd_o,
    output logic si_o,
    output logic serial_bus_line_a_o,
    output logic serial_bus_line_b_o,
    output logic sck_in_o,
    output logic [W_P2-1:0] p2_in_o,
    output logic [W_P7-1:0] p7_in_o
);
    // Read value of one port, bitwise over its pin role.
    function automatic logic [7:0] port_read(input logic [7:0] pin,
        input logic [7:0] lat, input logic [7:0] dir,
        input logic [7:0] fsel, input logic [7:0] cint, input logic pa);
        logic [7:0] nrm;
        nrm = pa ? (pin & ~dir) : ((pin & dir) | (lat & ~dir));
        return (fsel & ((pin & dir) | (cint & ~dir))) | (~fsel & nrm);
    endfunction

    // Byte write plus set mask in lane 1 and clear mask in lane 2.
    function automatic logic [7:0] lat_upd(input logic [7:0] old,
        input logic [3:0] sel, input logic [31:0] d);
        logic [7:0] v;
        v = sel[0] ? d[7:0] : old;
        v = sel[1] ? (v | d[15:8]) : v;
        v = sel[2] ? (v & ~d[23:16]) : v;
        return v;
    endfunction

    logic req;
    logic wr;
    logic [15:0] idx;
    logic [7:0] wbyte;
    logic [W_P0-1:0] lat0;
    logic [W_P3-1:0] lat3;
    logic [W_P4-1:0] lat4;
    logic [W_P5-1:0] lat5;
    logic [W_P8-1:0] lat8;
    logic [W_P9-1:0] lat9;
    logic [7:0] dir0;
    logic [W_P3-1:0] dir3;
    logic [7:0] dir5;
    logic [W_P8-1:0] dir8;
    logic [W_P9-1:0] dir9;
    logic p4dir;
    logic [7:0] fsel0;
    logic [W_P3-1:0] fsel3;
    logic [W_P8-1:0] fsel8;
    logic cmd;
    logic mod_a;
    logic mod_b;
    logic pa;
    logic [W_P0-1:0] s0;
    logic [W_P2-1:0] s2;
    logic [W_P3-1:0] s3;
    logic [W_P4-1:0] s4;
    logic [W_P5-1:0] s5;
    logic [W_P7-1:0] s7;
    logic [W_P8-1:0] s8;
    logic [W_P9-1:0] s9;
    logic [7:0] oe0c;
    logic [7:0] out0c;
    logic [W_P3-1:0] oe3c;
    logic [W_P3-1:0] out3c;
    logic [W_P3-1:0] int3c;
    logic so_mode;
    logic sb0_mode;
    logic sb1_mode;
    logic [7:0] rd0;
    logic [7:0] rd3;
    logic [7:0] rd4;
    logic [7:0] rd5;
    logic [7:0] rd8;
    logic [7:0] rd9;
    logic [7:0] nx0;
    logic [7:0] nx3;
    logic [7:0] nx4;
    logic [7:0] nx5;
    logic [7:0] nx8;
    logic [7:0] nx9;
    logic [31:0] next_dat;

    // Bus decode; a write lands at the edge where the master sees ack.
    assign req = cyc_i & stb_i;
    assign wr = req & we_i & ack_o;
    assign idx = adr_i[17:2];
    assign wbyte = dat_i[7:0];

    // Every pin level is synchronised before use.
    pio_sync_if #(.W(W_ALL)) sif ();
    assign sif.raw = {p9_i, p8_i, p7_i, p5_i, p4_i, p3_i, p2_i, p0_i};
    assign {s9, s8, s7, s5, s4, s3, s2, s0} = sif.stable;
    pio_pin_sync #(.W(W_ALL)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sif(sif)
    );

    // Ack one cycle after the request, then drop it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req & ~ack_o;
        end
    end

    // Read data is captured as ack rises and holds until the next read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req & ~we_i & ~ack_o) begin
            dat_o <= next_dat;
        end
    end

    // Latches carry no reset; software must load them first.
    // Writes reach the latch in any direction setting.
    assign nx0 = lat_upd(lat0, sel_i, dat_i);
    assign nx3 = lat_upd({3'b000, lat3}, sel_i, dat_i);
    assign nx4 = lat_upd(lat4, sel_i, dat_i);
    assign nx5 = lat_upd(lat5, sel_i, dat_i);
    assign nx8 = lat_upd({2'b00, lat8}, sel_i, dat_i);
    assign nx9 = lat_upd({5'b00000, lat9}, sel_i, dat_i);
    always_ff @(posedge clk_i) begin
        if (wr && idx == IDX_P0) lat0 <= nx0;
        if (wr && idx == IDX_P3) lat3 <= nx3[W_P3-1:0];
        if (wr && idx == IDX_P4) lat4 <= nx4;
        if (wr && idx == IDX_P5) lat5 <= nx5;
        if (wr && idx == IDX_P8) lat8 <= nx8[W_P8-1:0];
        if (wr && idx == IDX_P9) lat9 <= nx9[W_P9-1:0];
    end

    // Direction registers come out of reset as all inputs.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dir0 <= DIR_RST;
            dir3 <= DIR_RST[W_P3-1:0];
            dir5 <= DIR_RST;
            dir8 <= DIR_RST[W_P8-1:0];
            dir9 <= DIR_RST[W_P9-1:0];
            p4dir <= MEMX_P4DIR_RST;
        end else if (wr && sel_i[0]) begin
            if (idx == IDX_DIR0) dir0 <= wbyte;
            if (idx == IDX_DIR3) dir3 <= wbyte[W_P3-1:0];
            if (idx == IDX_DIR5) dir5 <= wbyte;
            if (idx == IDX_DIR8) dir8 <= wbyte[W_P8-1:0];
            if (idx == IDX_DIR9) dir9 <= wbyte[W_P9-1:0];
            if (idx == IDX_MEMX) p4dir <= wbyte[MEMX_P4DIR_BIT];
        end
    end

    // Function select and peripheral mode bits; set them once.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fsel0 <= FSEL_RST;
            fsel3 <= FSEL_RST[W_P3-1:0];
            fsel8 <= FSEL_RST[W_P8-1:0];
            cmd <= MODE_BIT_RST;
            mod_a <= MODE_BIT_RST;
            mod_b <= MODE_BIT_RST;
        end else if (wr && sel_i[0]) begin
            if (idx == IDX_FSEL0) fsel0 <= wbyte;
            if (idx == IDX_FSEL3) fsel3 <= wbyte[W_P3-1:0];
            if (idx == IDX_FSEL8) fsel8 <= wbyte[W_P8-1:0];
            if (idx == IDX_TUM) cmd <= wbyte[TUM_CMD_BIT];
            if (idx == IDX_CLOCKED_SERIAL_MODE_REG) begin
                mod_a <= wbyte[CLOCKED_SERIAL_MODE_REG_MOD_A_BIT];
                mod_b <= wbyte[CLOCKED_SERIAL_MODE_REG_MOD_B_BIT];
            end
        end
    end

    // Only bit 0 of readback control exists; the rest read zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa <= PIN_READBACK_CONTROL_PA_RST;
        end else if (wr && sel_i[0] && idx == IDX_PIN_READBACK_CONTROL) begin
            pa <= wbyte[PIN_READBACK_CONTROL_PA_BIT];
        end
    end

    // Port 0 roles: bits 5 to 7 become inputs in counter mode.
    assign oe0c = {{3{~cmd}}, 5'b11111};
    assign out0c = {1'b0, timer4_output_i, pwm_out_ch1_i, pwm_out_ch0_i,
        realtime_outputs_i};

    // Serial pins follow the two serial mode bits.
    assign so_mode = ~mod_a;
    assign sb0_mode = mod_a & ~mod_b;
    assign sb1_mode = mod_a & mod_b;
    assign oe3c = {sck_oe_i, sb1_mode & sbus_b_oe_i,
        so_mode | (sb0_mode & sbus_a_oe_i), 1'b0, 1'b1};
    assign out3c = {sck_out_i, sbus_b_out_i,
        so_mode ? so_i : sbus_a_out_i, 1'b0, txd_i};
    assign int3c = {sck_out_i, so_mode ? 1'b0 : sbus_b_out_i,
        out3c[2], 1'b0, txd_i};

    // Pin drivers: a select bit hands the pin over to control.
    // Otherwise direction zero drives the latch.
    assign p0_oe_o = (fsel0 & oe0c) | (~fsel0 & ~dir0);
    assign p0_o = (fsel0 & out0c) | (~fsel0 & lat0);
    assign p3_oe_o = (fsel3 & oe3c) | (~fsel3 & ~dir3);
    assign p3_o = (fsel3 & out3c) | (~fsel3 & lat3);
    assign p8_oe_o = fsel8 | ~dir8;
    assign p8_o = (fsel8 & timer0_outputs_i) | (~fsel8 & lat8);
    assign p4_oe_o = {W_P4{~p4dir}};
    assign p4_o = lat4;
    assign p5_oe_o = ~dir5;
    assign p5_o = lat5;
    assign p9_oe_o = ~dir9;
    assign p9_o = lat9;

    // Read mux per port; widths zero-pad the upper bits.
    // Control reads follow pin or internal signal.
    // Outputs read latch, inputs read pin; readback mode: outputs read pin, inputs zero.
    assign rd0 = port_read(s0, lat0, dir0, fsel0, out0c, pa)
        & ~{fsel0[7] & ~cmd, 7'h00};
    assign rd3 = port_read({3'b000, s3}, {3'b000, lat3}, {3'b000, dir3},
        {3'b000, fsel3}, {3'b000, int3c}, pa);
    assign rd4 = port_read(s4, lat4, {W_P4{p4dir}}, 8'h00, 8'h00, pa);
    assign rd5 = port_read(s5, lat5, dir5, 8'h00, 8'h00, pa);
    assign rd8 = port_read({2'b00, s8}, {2'b00, lat8}, {2'b00, dir8},
        {2'b00, fsel8}, {2'b00, timer0_outputs_i}, pa);
    assign rd9 = port_read({5'b00000, s9}, {5'b00000, lat9},
        {5'b00000, dir9}, 8'h00, 8'h00, pa);

    // Register read decode; unmapped indices read zero.
    always_comb begin
        next_dat = 32'h0000_0000;
        case (idx)
            IDX_P0: next_dat[7:0] = rd0;
            IDX_P2: next_dat[W_P2-1:0] = s2;
            IDX_P3: next_dat[7:0] = rd3;
            IDX_P4: next_dat[7:0] = rd4;
            IDX_P5: next_dat[7:0] = rd5;
            IDX_P7: next_dat[W_P7-1:0] = s7;
            IDX_P8: next_dat[7:0] = rd8;
            IDX_P9: next_dat[7:0] = rd9;
            IDX_DIR0: next_dat[7:0] = dir0;
            IDX_DIR3: next_dat[W_P3-1:0] = dir3;
            IDX_DIR5: next_dat[7:0] = dir5;
            IDX_DIR8: next_dat[W_P8-1:0] = dir8;
            IDX_DIR9: next_dat[W_P9-1:0] = dir9;
            IDX_FSEL0: next_dat[7:0] = fsel0;
            IDX_FSEL3: next_dat[W_P3-1:0] = fsel3;
            IDX_FSEL8: next_dat[W_P8-1:0] = fsel8;
            IDX_MEMX: next_dat[MEMX_P4DIR_BIT] = p4dir;
            IDX_TUM: next_dat[TUM_CMD_BIT] = cmd;
            IDX_CLOCKED_SERIAL_MODE_REG: next_dat[CLOCKED_SERIAL_MODE_REG_MOD_B_BIT:CLOCKED_SERIAL_MODE_REG_MOD_A_BIT] = {mod_b,
                mod_a};
            IDX_PIN_READBACK_CONTROL: next_dat[PIN_READBACK_CONTROL_PA_BIT] = pa;
            default: next_dat = 32'h0000_0000;
        endcase
    end

    // Synchronised levels to peripheral inputs; gating avoids glitches.
    assign updown_count_input_o = s0[5] & cmd & fsel0[5];
    assign updown_timer_input_o = s0[6] & cmd & fsel0[6];
    assign updown_clear_input_o = s0[7] & cmd & fsel0[7];
    assign rxd_o = s3[1];
    assign si_o = s3[3];
    assign serial_bus_line_a_o = s3[2];
    assign serial_bus_line_b_o = s3[3];
    assign sck_in_o = s3[4];
    assign p2_in_o = s2;
    assign p7_in_o = s7;

    // Checks of the documented behaviour.
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic rd_ack;
    assign rd_ack = ack_o & req & ~we_i;

    a_reset_all_input:
    assert property (disable iff (1'b0) rst_i |=> (p0_oe_o == 8'h00
        && p3_oe_o == 5'h00 && p4_oe_o == 8'h00 && p5_oe_o == 8'h00
        && p8_oe_o == 6'h00 && p9_oe_o == 3'h00))
    else $error("Pins driven after reset.");

    a_readback_reset:
    assert property (disable iff (1'b0) rst_i ##1 !rst_i |-> !pa)
    else $error("Readback mode set after reset.");

    a_output_drive:
    assert property (fsel0 == 8'h00 |-> p0_oe_o == ~dir0
        && (p0_o & ~dir0) == (lat0 & ~dir0))
    else $error("Port 0 output does not follow latch and direction.");

    a_write_latch:
    assert property (wr && idx == IDX_P5 && sel_i == 4'h1
        |=> lat5 == $past(wbyte))
    else $error("Port 5 latch missed a write.");

    a_read_latch:
    assert property (rd_ack && idx == IDX_P5 && $past(dir5) == 8'h00
        && !$past(pa) |-> dat_o[7:0] == $past(lat5))
    else $error("Output port read did not return the latch.");

    a_read_pin:
    assert property (rd_ack && idx == IDX_P5 && $past(dir5) == 8'hff
        && !$past(pa) |-> dat_o[7:0] == $past(s5))
    else $error("Input port read did not return the pin.");

    a_pin_access_zero:
    assert property (rd_ack && idx == IDX_P9 && $past(pa)
        && $past(dir9) == 3'h7 |-> dat_o == 32'h0000_0000)
    else $error("Input read in readback mode not zero.");

    a_pin_access_out:
    assert property (rd_ack && idx == IDX_P5 && $past(pa)
        |-> dat_o[7:0] == ($past(s5) & ~$past(dir5)))
    else $error("Readback mode did not return pin level.");

    a_pin_readback_control_upper_zero:
    assert property (rd_ack && idx == IDX_PIN_READBACK_CONTROL |-> dat_o[31:1] == 31'h0)
    else $error("Readback control upper bits not zero.");

    a_bit7_zero:
    assert property (fsel0[7] && !cmd |-> p0_o[7] == 1'b0 && p0_oe_o[7])
    else $error("Port 0 bit 7 not driving zero.");

    a_ctl_in_zero:
    assert property (rd_ack && idx == IDX_P3 && $past(fsel3[1])
        && !$past(dir3[1]) |-> dat_o[1] == 1'b0)
    else $error("Control input read not zero.");
endmodule
`default_nettype wire

// ---- bench/pio_pin_model.sv ----
/*
 * Model of the circuitry on a group of port pins.
 * Assumes the block drives each pin only while its enable is high.
 */
`timescale 1ns/100ps
`default_nettype none
module pio_pin_model #(
    parameter int W = 8
) (
    // Drive from the block.
    input wire logic [W-1:0] drv_i,
    input wire logic [W-1:0] oe_i,
    // Outside source level and injected fault.
    input wire logic [W-1:0] ext_i,
    input wire logic flip_i,
    // Resolved pin level.
    output logic [W-1:0] pin_o
);
    // A released pin shows the outside source, never a stale drive.
    // The fault inverts bit 0 so that a pin read differs from the latch.
    assign pin_o = (oe_i & (drv_i ^ W'(flip_i))) | (~oe_i & ext_i);
endmodule
`default_nettype wire

// ---- bench/pio_port_io_test.sv ----
/*
 * Self-checking bench of the port block over classic Wishbone.
 * Assumes pio_pkg, the design and pio_pin_model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module pio_port_io_test
    import pio_pkg::*;
;
    // Master and stimulus state, changed only just after a rising edge.
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [ADR_W-1:0] adr = '0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [7:0] ext = 8'h00;
    logic flip = 1'b0;
    logic [20:0] per = 21'h00_0aa0;
    // Design outputs and resolved pins.
    logic [31:0] dat_o;
    logic ack_o, rxd_o, ud_cnt, ud_clr;
    logic [7:0] p0_o, p0_oe, p0_pin, p4_o, p4_oe, p4_pin, p5_o, p5_oe, p5_pin;
    logic [4:0] p3_o, p3_oe, p3_pin;
    logic [5:0] p8_o, p8_oe, p8_pin, p2_in;
    logic [2:0] p9_o, p9_oe, p9_pin;
    logic [7:0] p7_in;
    int n_mismatch = 0, n_checks = 0;

    // System clock of 100 ns period.
    always #50 clk_i = ~clk_i;

    pio_port_io i_pio_port_io (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .p0_i(p0_pin), .p0_o(p0_o), .p0_oe_o(p0_oe), .p2_i(ext[5:0]),
        .p3_i(p3_pin), .p3_o(p3_o), .p3_oe_o(p3_oe), .p4_i(p4_pin),
        .p4_o(p4_o), .p4_oe_o(p4_oe), .p5_i(p5_pin), .p5_o(p5_o),
        .p5_oe_o(p5_oe), .p7_i(~ext), .p8_i(p8_pin), .p8_o(p8_o),
        .p8_oe_o(p8_oe), .p9_i(p9_pin), .p9_o(p9_o), .p9_oe_o(p9_oe),
        .realtime_outputs_i(per[3:0]), .pwm_out_ch0_i(per[4]),
        .pwm_out_ch1_i(per[5]), .timer4_output_i(per[6]),
        .timer0_outputs_i(per[12:7]), .txd_i(per[13]), .so_i(per[14]),
        .sbus_a_out_i(per[15]), .sbus_a_oe_i(per[16]),
        .sbus_b_out_i(per[17]), .sbus_b_oe_i(per[18]),
        .sck_out_i(per[19]), .sck_oe_i(per[20]),
        .updown_count_input_o(ud_cnt), .updown_timer_input_o(),
        .updown_clear_input_o(ud_clr), .rxd_o(rxd_o), .si_o(),
        .serial_bus_line_a_o(), .serial_bus_line_b_o(), .sck_in_o(),
        .p2_in_o(p2_in), .p7_in_o(p7_in)
    );

    // Pins of the bidirectional ports; the fault shows only on driven pins.
    pio_pin_model #(.W(8)) i_pio_pin_model_p0 (.drv_i(p0_o), .oe_i(p0_oe),
        .ext_i(ext), .flip_i(flip), .pin_o(p0_pin));
    pio_pin_model #(.W(5)) i_pio_pin_model_p3 (.drv_i(p3_o), .oe_i(p3_oe),
        .ext_i(ext[4:0]), .flip_i(flip), .pin_o(p3_pin));
    pio_pin_model #(.W(8)) i_pio_pin_model_p4 (.drv_i(p4_o), .oe_i(p4_oe),
        .ext_i(ext), .flip_i(flip), .pin_o(p4_pin));
    pio_pin_model #(.W(3)) i_pio_pin_model_p9 (.drv_i(p9_o), .oe_i(p9_oe),
        .ext_i(ext[2:0]), .flip_i(flip), .pin_o(p9_pin));
    pio_pin_model #(.W(8)) i_pio_pin_model_p5 (.drv_i(p5_o), .oe_i(p5_oe),
        .ext_i(ext), .flip_i(flip), .pin_o(p5_pin));
    pio_pin_model #(.W(6)) i_pio_pin_model_p8 (.drv_i(p8_o), .oe_i(p8_oe),
        .ext_i(ext[5:0]), .flip_i(flip), .pin_o(p8_pin));

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Value compare; case inequality so that unknowns never match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [15:0] idx,
            input logic [3:0] s, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            n_mismatch++;
            results();
        end
    endtask

    // Byte write and masked read of an 8-bit register.
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, 4'h1, {24'h00_0000, d}, q);
    endtask
    task automatic rd(input logic [15:0] idx, input logic [7:0] m,
            input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, idx, 4'h0, 32'h0000_0000, q);
        chk(q & {24'hff_ffff, m}, {24'h00_0000, e});
    endtask

    // Reset state: all pins released, readback off.
    task automatic t_reset();
        @(negedge clk_i);
        chk(32'(|{p0_oe, p3_oe, p4_oe, p5_oe, p8_oe, p9_oe}), 32'h0);
        rd(IDX_DIR0, 8'hff, 8'hff);
        rd(IDX_DIR5, 8'hff, 8'hff);
        rd(IDX_PIN_READBACK_CONTROL, 8'hff, 8'h00);
        rd(IDX_MEMX, 8'h01, 8'h01);
    endtask

    // Input read, latch write while input, then turn to output.
    task automatic t_latch();
        logic [31:0] q;
        ext <= 8'ha5;
        repeat (6) @(posedge clk_i);
        rd(IDX_P5, 8'hff, 8'ha5);
        wr(IDX_P5, 8'h3c);
        @(negedge clk_i);
        chk(32'(p5_oe), 32'h0000_0000);
        rd(IDX_P5, 8'hff, 8'ha5);
        wr(IDX_DIR5, 8'h00);
        @(negedge clk_i);
        chk(32'({p5_oe, p5_o}), 32'h0000_ff3c);
        rd(IDX_P5, 8'hff, 8'h3c);
        wb(1'b1, IDX_P5, 4'h2, 32'h0000_0200, q);
        wb(1'b1, IDX_P5, 4'h4, 32'h000c_0000, q);
        rd(IDX_P5, 8'hff, 8'h32);
    endtask

    // Readback with a faulty bit 0: pins read, inputs read as zero.
    task automatic t_readback();
        wr(IDX_DIR5, 8'hf0);
        flip <= 1'b1;
        wr(IDX_PIN_READBACK_CONTROL, 8'h01);
        repeat (6) @(posedge clk_i);
        rd(IDX_P5, 8'hff, 8'h03);
        rd(IDX_P9, 8'h07, 8'h00);
        wr(IDX_PIN_READBACK_CONTROL, 8'hff);
        rd(IDX_PIN_READBACK_CONTROL, 8'hff, 8'h01);
        wr(IDX_PIN_READBACK_CONTROL, 8'h00);
        rd(IDX_P5, 8'hff, 8'ha2);
        rd(IDX_P9, 8'h07, 8'h05);
        flip <= 1'b0;
    endtask

    // Port 4 direction from the mode field; dedicated input ports.
    task automatic t_port4_inputs();
        wr(IDX_P4, 8'h5a);
        wr(IDX_MEMX, 8'h00);
        @(negedge clk_i);
        chk(32'({p4_oe, p4_o}), 32'h0000_ff5a);
        wr(IDX_MEMX, 8'h01);
        @(negedge clk_i);
        chk(32'(p4_oe), 32'h0000_0000);
        wr(IDX_P2, 8'h00);
        rd(IDX_P2, 8'hff, 8'h25);
        rd(IDX_P7, 8'hff, 8'h5a);
        chk(32'(p2_in), 32'h0000_0025);
        chk(32'(p7_in), 32'h0000_005a);
    endtask

    // Peripheral outputs on port 8 and a peripheral input on port 3.
    task automatic t_function();
        wr(IDX_FSEL8, 8'h3f);
        wr(IDX_DIR8, 8'h00);
        @(negedge clk_i);
        chk(32'({p8_oe, p8_o}), 32'h0000_0fd5);
        rd(IDX_P8, 8'h3f, 8'h15);
        flip <= 1'b1;
        wr(IDX_DIR8, 8'h3f);
        repeat (6) @(posedge clk_i);
        rd(IDX_P8, 8'h3f, 8'h14);
        flip <= 1'b0;
        ext <= 8'ha7;
        wr(IDX_FSEL3, 8'h02);
        wr(IDX_DIR3, 8'h1d);
        repeat (6) @(posedge clk_i);
        rd(IDX_P3, 8'h02, 8'h00);
        wr(IDX_DIR3, 8'h1f);
        rd(IDX_P3, 8'h02, 8'h02);
        chk(32'(rxd_o), 32'h0000_0001);
        per <= 21'h1f_6aa0;
        wr(IDX_FSEL3, 8'h1f);
        @(negedge clk_i);
        chk(32'({p3_oe, p3_o & p3_oe}), 32'h0000_02b5);
        wr(IDX_CLOCKED_SERIAL_MODE_REG, 8'h08);
        @(negedge clk_i);
        chk(32'({p3_oe, p3_o & p3_oe}), 32'h0000_02b1);
        wr(IDX_CLOCKED_SERIAL_MODE_REG, 8'h18);
        @(negedge clk_i);
        chk(32'({p3_oe, p3_o & p3_oe}), 32'h0000_0339);
    endtask

    // Counter mode off and on for port 0 bits 5 and 7.
    task automatic t_counter();
        wr(IDX_TUM, 8'h00);
        wr(IDX_FSEL0, 8'h80);
        wr(IDX_P0, 8'h00);
        wr(IDX_DIR0, 8'h00);
        @(negedge clk_i);
        chk(32'(p0_o[7]), 32'h0000_0000);
        rd(IDX_P0, 8'h80, 8'h00);
        wr(IDX_TUM, 8'h80);
        wr(IDX_FSEL0, 8'ha0);
        repeat (6) @(posedge clk_i);
        rd(IDX_P0, 8'ha0, 8'h20);
        chk(32'({ud_clr, ud_cnt}), 32'h0000_0003);
    endtask

    // Reset for ten cycles, then the scenarios in order.
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_latch();
        t_readback();
        t_port4_inputs();
        t_function();
        t_counter();
        results();
    end
endmodule
`default_nettype wire
